// *** logic/hig_pkg.sv ***
// Behaviour
// - Output asserts only with global enable set.
// - Mode bit 1 picks level or edge.
// - Mode bit 2 picks active low or high.
// - Reset default: level triggered, active low.
// - Edge mode emits a programmed-width pulse.
// - Timing bits 15:0 set width, FFFFh ~ 1 ms.
// - Default pulse width about 500 ns.
// - Timing bits 31:24 set minimum interrupt gap.
// - Writing one clears status; zero keeps it.
// - Disabled events set status, no output.
// - Level mode: output active when enabled status bit set.
// - Level output holds until enabled bits cleared.
// - Started pulse runs full length while edge mode and global enable stay set.
// - Generation keeps running with clocks stopped elsewhere.
// - OR mask hit raises interrupt, beats AND.
// - AND mask raises once all selected done.
// - One mask pair per descriptor category.
// - Bulk completions paced by done interval.
// - Done maps show which descriptors completed.
package hig_pkg;

  // Bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // Event and descriptor geometry.
  localparam int EVT_W = 16;
  localparam int NUM_CAT = 3;
  localparam int MAP_W = 16;
  localparam int EXT_EVT_W = EVT_W - NUM_CAT;
  localparam int CAT_ISO = 0;
  localparam int CAT_INT = 1;
  localparam int CAT_ASYNC = 2;

  // Register byte offsets; per-category registers sit one word apart.
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_EDGE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_DONE_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_AND_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_OR_BASE = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_BULK = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_STRIDE = 8'h04;

  // Field positions.
  localparam int MODE_GLOBAL_BIT = 0;
  localparam int MODE_TRIG_BIT = 1;
  localparam int MODE_POL_BIT = 2;
  localparam int EDGE_WIDTH_LSB = 0;
  localparam int EDGE_WIDTH_W = 16;
  localparam int EDGE_GAP_LSB = 24;
  localparam int EDGE_GAP_W = 8;
  localparam int BULK_EN_BIT = 31;
  localparam int BULK_IVL_LSB = 0;
  localparam int BULK_IVL_W = 16;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Timing: the width code maps linearly onto 0 .. 1 ms.
  localparam int CLK_PERIOD_NS = 10;
  localparam longint EDGE_FULL_NS = 1000000;
  localparam longint EDGE_MAX_CODE = 65535;
  localparam longint EDGE_DEF_NS = 500;
  localparam int FRAC_W = 16;
  localparam int ACC_W = 32;
  localparam logic [EDGE_WIDTH_W-1:0] EDGE_STEP = EDGE_WIDTH_W'(
    (EDGE_MAX_CODE * CLK_PERIOD_NS * (64'd1 << FRAC_W)) / EDGE_FULL_NS);
  localparam logic [EDGE_WIDTH_W-1:0] EDGE_DEF_CODE = EDGE_WIDTH_W'(
    (EDGE_DEF_NS * EDGE_MAX_CODE + EDGE_FULL_NS - 1) / EDGE_FULL_NS);
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 8;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  // Mode control fields.
  typedef struct packed {
    logic polarity;
    logic trigger;
    logic global_en;
  } hig_mode_type;

  // Edge pulse timing fields.
  typedef struct packed {
    logic [EDGE_GAP_W-1:0] gap;
    logic [EDGE_WIDTH_W-1:0] width;
  } hig_edge_cfg_type;

  // Edge pulse sequencer states.
  typedef enum logic [1:0] {
    EDGE_IDLE = 2'b00,
    EDGE_PULSE = 2'b01,
    EDGE_GAP = 2'b10
  } hig_edge_state_type;

endpackage : hig_pkg

// *** logic/hig_mask_eval.sv ***
`timescale 1ns/1ns
`default_nettype none
module hig_mask_eval (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Category done map and masks.
  input wire logic [hig_pkg::MAP_W-1:0] done_map,
  input wire logic [hig_pkg::MAP_W-1:0] and_mask,
  input wire logic [hig_pkg::MAP_W-1:0] or_mask,
  // One-cycle request to set the category's status bit.
  output logic raise
);

  logic [hig_pkg::MAP_W-1:0] done_prev_r; // Done map one cycle ago.
  logic and_ok_r; // AND condition one cycle ago.
  logic raise_r; // Registered request.
  logic [hig_pkg::MAP_W-1:0] and_eff; // AND bits not already owned by OR.
  logic and_ok; // All AND-selected bits are done.
  logic or_new; // A newly done bit hits the OR mask.

  // Bits under the OR mask are left out of the AND test, so OR wins.
  always_comb begin
    and_eff = and_mask & ~or_mask;
    and_ok = (and_eff != '0) && ((done_map & and_eff) == and_eff);
    or_new = |(done_map & or_mask & ~done_prev_r);
  end

  // Each OR bit raises once as it completes; AND raises once on completion of the set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_prev_r <= '0;
      and_ok_r <= 1'b0;
      raise_r <= 1'b0;
    end else begin
      done_prev_r <= done_map;
      and_ok_r <= and_ok;
      raise_r <= or_new | (and_ok & ~and_ok_r);
    end
  end

  assign raise = raise_r;

endmodule : hig_mask_eval
`default_nettype wire

// *** logic/hig_irq_core.sv ***
`timescale 1ns/1ns
`default_nettype none
module hig_irq_core (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel.
  input wire logic [hig_pkg::ADDR_W-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  // Write data channel.
  input wire logic [hig_pkg::DATA_W-1:0] s_axil_wdata,
  input wire logic [hig_pkg::STRB_W-1:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  // Write response channel.
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // Read address channel.
  input wire logic [hig_pkg::ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  // Read data channel.
  output logic [hig_pkg::DATA_W-1:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Controller events, one-cycle pulses.
  input wire logic [hig_pkg::EXT_EVT_W-1:0] ext_event,
  input wire logic [hig_pkg::NUM_CAT-1:0][hig_pkg::MAP_W-1:0] td_done,
  // Interrupt line toward the processor.
  output logic irq_pin
);

  // Byte-lane merge of a write into a stored word.
  function automatic logic [hig_pkg::DATA_W-1:0] merge(
    input logic [hig_pkg::DATA_W-1:0] old_v,
    input logic [hig_pkg::DATA_W-1:0] new_v,
    input logic [hig_pkg::STRB_W-1:0] strb);
    logic [hig_pkg::DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < hig_pkg::STRB_W; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Address of a per-category register.
  function automatic logic [hig_pkg::ADDR_W-1:0] cat_addr(
    input logic [hig_pkg::ADDR_W-1:0] base, input int cat);
    return base + hig_pkg::ADDR_W'(cat) * hig_pkg::OFF_STRIDE;
  endfunction : cat_addr

  // True when an address hits a mapped register.
  function automatic logic mapped(input logic [hig_pkg::ADDR_W-1:0] a);
    logic hit;
    hit = (a == hig_pkg::OFF_MODE) || (a == hig_pkg::OFF_STATUS) ||
          (a == hig_pkg::OFF_ENABLE) || (a == hig_pkg::OFF_EDGE) || (a == hig_pkg::OFF_BULK);
    for (int c = 0; c < hig_pkg::NUM_CAT; c++) begin
      hit = hit || (a == cat_addr(hig_pkg::OFF_DONE_BASE, c)) ||
            (a == cat_addr(hig_pkg::OFF_AND_BASE, c)) || (a == cat_addr(hig_pkg::OFF_OR_BASE, c));
    end
    return hit;
  endfunction : mapped

  // Software-visible state.
  hig_pkg::hig_mode_type mode_r; // Enable, trigger and polarity.
  logic [hig_pkg::EVT_W-1:0] status_r; // Sticky event status.
  logic [hig_pkg::EVT_W-1:0] enable_r; // Per-event enables.
  hig_pkg::hig_edge_cfg_type edge_cfg_r; // Pulse width and gap.
  logic [hig_pkg::NUM_CAT-1:0][hig_pkg::MAP_W-1:0] done_r; // Sticky done maps.
  logic [hig_pkg::NUM_CAT-1:0][hig_pkg::MAP_W-1:0] and_r; // AND masks.
  logic [hig_pkg::NUM_CAT-1:0][hig_pkg::MAP_W-1:0] or_r; // OR masks.
  logic bulk_en_r; // Bulk interval pacing on.
  logic [hig_pkg::BULK_IVL_W-1:0] bulk_ivl_r; // Bulk interval in ticks.

  // Bus slave state.
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_held_r, w_held_r;
  logic [hig_pkg::ADDR_W-1:0] aw_addr_r;
  logic [hig_pkg::DATA_W-1:0] w_data_r;
  logic [hig_pkg::STRB_W-1:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [hig_pkg::DATA_W-1:0] rdata_r;
  logic wr_fire; // Both halves of a write are in hand.
  logic [hig_pkg::DATA_W-1:0] rd_mux; // Read data for the requested address.

  // Event paths.
  logic [hig_pkg::NUM_CAT-1:0] cat_raise; // Category mask hits.
  logic [hig_pkg::EVT_W-1:0] status_set; // Bits set this cycle.
  logic [hig_pkg::EVT_W-1:0] status_clr; // Bits cleared by a write.
  logic async_pend_r; // Bulk completion waiting for the interval.
  logic [hig_pkg::BULK_IVL_W-1:0] bulk_cnt_r; // Interval progress.
  logic bulk_expire; // Interval elapsed this tick.
  logic [hig_pkg::TICK_W-1:0] tick_cnt_r; // Timebase prescaler.
  logic tick; // One-cycle timebase tick.

  // Output sequencing.
  hig_pkg::hig_edge_state_type edge_state_r;
  logic edge_pend_r; // An enabled event awaits a pulse.
  logic [hig_pkg::ACC_W-1:0] width_acc_r; // Fixed-point pulse progress.
  logic [hig_pkg::EDGE_GAP_W-1:0] gap_cnt_r; // Gap progress in ticks.
  logic pulse_done; // Pulse has reached its programmed width.
  logic irq_active; // Line should show asserted.
  logic irq_pin_r;

  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;

  // Write address half: taken alone, held until the write completes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axil_awvalid && awready_r) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axil_awaddr;
      awready_r <= 1'b0;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end else if (!aw_held_r && !bvalid_r) begin
      awready_r <= 1'b1;
    end
  end

  // Write data half, mirroring the address half so either may come first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b0;
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axil_wvalid && wready_r) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axil_wdata;
      w_strb_r <= s_axil_wstrb;
      wready_r <= 1'b0;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end else if (!w_held_r && !bvalid_r) begin
      wready_r <= 1'b1;
    end
  end

  // Write response; unmapped addresses answer with a decode error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= hig_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= mapped(aw_addr_r) ? hig_pkg::RESP_OKAY : hig_pkg::RESP_DECERR;
    end else if (s_axil_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read mux; reserved bits read as zero.
  always_comb begin
    rd_mux = '0;
    case (s_axil_araddr)
      hig_pkg::OFF_MODE: rd_mux[hig_pkg::MODE_POL_BIT:hig_pkg::MODE_GLOBAL_BIT] = mode_r;
      hig_pkg::OFF_STATUS: rd_mux[hig_pkg::EVT_W-1:0] = status_r;
      hig_pkg::OFF_ENABLE: rd_mux[hig_pkg::EVT_W-1:0] = enable_r;
      hig_pkg::OFF_EDGE: begin
        rd_mux[hig_pkg::EDGE_WIDTH_LSB +: hig_pkg::EDGE_WIDTH_W] = edge_cfg_r.width;
        rd_mux[hig_pkg::EDGE_GAP_LSB +: hig_pkg::EDGE_GAP_W] = edge_cfg_r.gap;
      end
      hig_pkg::OFF_BULK: begin
        rd_mux[hig_pkg::BULK_EN_BIT] = bulk_en_r;
        rd_mux[hig_pkg::BULK_IVL_LSB +: hig_pkg::BULK_IVL_W] = bulk_ivl_r;
      end
      default: begin
        // Per-category maps and masks; the done maps tell which descriptors completed.
        for (int c = 0; c < hig_pkg::NUM_CAT; c++) begin
          if (s_axil_araddr == cat_addr(hig_pkg::OFF_DONE_BASE, c)) begin
            rd_mux[hig_pkg::MAP_W-1:0] = done_r[c];
          end
          if (s_axil_araddr == cat_addr(hig_pkg::OFF_AND_BASE, c)) begin
            rd_mux[hig_pkg::MAP_W-1:0] = and_r[c];
          end
          if (s_axil_araddr == cat_addr(hig_pkg::OFF_OR_BASE, c)) begin
            rd_mux[hig_pkg::MAP_W-1:0] = or_r[c];
          end
        end
      end
    endcase
  end

  // Read channel: one read at a time, answered the cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= hig_pkg::RESP_OKAY;
    end else if (s_axil_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= mapped(s_axil_araddr) ? hig_pkg::RESP_OKAY : hig_pkg::RESP_DECERR;
    end else if (rvalid_r && s_axil_rready) begin
      rvalid_r <= 1'b0;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  // Plain control registers; reset leaves level mode, active low, disabled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= '0;
      enable_r <= '0;
      edge_cfg_r.width <= hig_pkg::EDGE_DEF_CODE;
      edge_cfg_r.gap <= '0;
      bulk_en_r <= 1'b0;
      bulk_ivl_r <= '0;
    end else if (wr_fire) begin
      case (aw_addr_r)
        hig_pkg::OFF_MODE: begin
          if (w_strb_r[0]) begin
            mode_r.global_en <= w_data_r[hig_pkg::MODE_GLOBAL_BIT];
            mode_r.trigger <= w_data_r[hig_pkg::MODE_TRIG_BIT];
            mode_r.polarity <= w_data_r[hig_pkg::MODE_POL_BIT];
          end
        end
        hig_pkg::OFF_ENABLE: begin
          enable_r <= hig_pkg::EVT_W'(merge(hig_pkg::DATA_W'(enable_r), w_data_r, w_strb_r));
        end
        hig_pkg::OFF_EDGE: begin
          edge_cfg_r <= {hig_pkg::EDGE_GAP_W'(merge(hig_pkg::DATA_W'(edge_cfg_r.gap) <<
                           hig_pkg::EDGE_GAP_LSB, w_data_r, w_strb_r) >> hig_pkg::EDGE_GAP_LSB),
                         hig_pkg::EDGE_WIDTH_W'(merge(hig_pkg::DATA_W'(edge_cfg_r.width), w_data_r,
                               w_strb_r))};
        end
        hig_pkg::OFF_BULK: begin
          if (w_strb_r[hig_pkg::STRB_W-1]) begin
            bulk_en_r <= w_data_r[hig_pkg::BULK_EN_BIT];
          end
          bulk_ivl_r <= hig_pkg::BULK_IVL_W'(merge(hig_pkg::DATA_W'(bulk_ivl_r), w_data_r,
                              w_strb_r) >> hig_pkg::BULK_IVL_LSB);
        end
        default: begin
          // Other addresses are handled by their own processes or ignored.
        end
      endcase
    end
  end

  // Masks and sticky done maps, one set per descriptor category.
  for (genvar c = 0; c < hig_pkg::NUM_CAT; c++) begin : g_cat
    logic [hig_pkg::MAP_W-1:0] done_clr; // Write-one-to-clear bits.

    always_comb begin
      done_clr = '0;
      if (wr_fire && aw_addr_r == cat_addr(hig_pkg::OFF_DONE_BASE, c)) begin
        done_clr = hig_pkg::MAP_W'(merge('0, w_data_r, w_strb_r));
      end
    end

    // A completion in the cycle of its clear survives: the set is applied last.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        done_r[c] <= '0;
        and_r[c] <= '0;
        or_r[c] <= '0;
      end else begin
        done_r[c] <= (done_r[c] & ~done_clr) | td_done[c];
        if (wr_fire && aw_addr_r == cat_addr(hig_pkg::OFF_AND_BASE, c)) begin
          and_r[c] <= hig_pkg::MAP_W'(merge(hig_pkg::DATA_W'(and_r[c]), w_data_r, w_strb_r));
        end
        if (wr_fire && aw_addr_r == cat_addr(hig_pkg::OFF_OR_BASE, c)) begin
          or_r[c] <= hig_pkg::MAP_W'(merge(hig_pkg::DATA_W'(or_r[c]), w_data_r, w_strb_r));
        end
      end
    end

    // Each category sees only its own map and masks.
    hig_mask_eval u_eval (
      .aclk(aclk),
      .aresetn(aresetn),
      .done_map(done_r[c]),
      .and_mask(and_r[c]),
      .or_mask(or_r[c]),
      .raise(cat_raise[c])
    );
  end

  // Shared timebase for the gap and the bulk interval.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= (tick_cnt_r == hig_pkg::TICK_LAST) ? '0 : tick_cnt_r + 1'b1;
    end
  end
  assign tick = (tick_cnt_r == hig_pkg::TICK_LAST);

  // Bulk pacing: a zero interval is treated as one tick, never as a stall.
  assign bulk_expire = tick && (bulk_cnt_r + 1'b1 >= bulk_ivl_r);

  // Bulk completions wait for the next interval boundary before they may raise.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bulk_cnt_r <= '0;
      async_pend_r <= 1'b0;
    end else if (!bulk_en_r) begin
      bulk_cnt_r <= '0;
      async_pend_r <= 1'b0;
    end else begin
      if (tick) begin
        bulk_cnt_r <= bulk_expire ? '0 : bulk_cnt_r + 1'b1;
      end
      async_pend_r <= (async_pend_r && !bulk_expire) || cat_raise[hig_pkg::CAT_ASYNC];
    end
  end

  // Events feeding the status register; disabled ones still set their bit.
  always_comb begin
    status_set = {ext_event, cat_raise};
    if (bulk_en_r) begin
      status_set[hig_pkg::CAT_ASYNC] = async_pend_r && bulk_expire;
    end
    status_clr = '0;
    if (wr_fire && aw_addr_r == hig_pkg::OFF_STATUS) begin
      status_clr = hig_pkg::EVT_W'(merge('0, w_data_r, w_strb_r));
    end
  end

  // Write-one-to-clear status; an event in the clearing cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~status_clr) | status_set;
    end
  end

  // Pulse length grows linearly with the code: a fixed fraction per clock.
  assign pulse_done = width_acc_r[hig_pkg::ACC_W-1 -: hig_pkg::EDGE_WIDTH_W] >= edge_cfg_r.width;

  // Edge sequencer: pulse, optional gap, then ready for the next pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_state_r <= hig_pkg::EDGE_IDLE;
      width_acc_r <= '0;
      gap_cnt_r <= '0;
    end else begin
      case (edge_state_r)
        hig_pkg::EDGE_IDLE: begin
          width_acc_r <= '0;
          gap_cnt_r <= '0;
          if (edge_pend_r && mode_r.trigger && mode_r.global_en) begin
            edge_state_r <= hig_pkg::EDGE_PULSE;
          end
        end
        hig_pkg::EDGE_PULSE: begin
          // Status clears do not reach here, so the pulse always runs out.
          width_acc_r <= width_acc_r + hig_pkg::ACC_W'(hig_pkg::EDGE_STEP);
          if (pulse_done) begin
            edge_state_r <= (edge_cfg_r.gap != '0) ? hig_pkg::EDGE_GAP : hig_pkg::EDGE_IDLE;
          end
        end
        hig_pkg::EDGE_GAP: begin
          // Events arriving now only accumulate in the pending flag.
          if (tick) begin
            gap_cnt_r <= gap_cnt_r + 1'b1;
            if (gap_cnt_r + 1'b1 >= edge_cfg_r.gap) begin
              edge_state_r <= hig_pkg::EDGE_IDLE;
            end
          end
        end
        default: begin
          edge_state_r <= hig_pkg::EDGE_IDLE;
        end
      endcase
    end
  end

  // Pending edge request: set by enabled events in edge mode only, so level-mode traffic
  // never leaves a stale pulse behind for a later switch to edge mode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_pend_r <= 1'b0;
    end else begin
      edge_pend_r <= (edge_pend_r && !(edge_state_r == hig_pkg::EDGE_IDLE && mode_r.trigger
                                       && mode_r.global_en))
                     || (|(status_set & enable_r) && mode_r.global_en && mode_r.trigger);
    end
  end

  // Asserted level before polarity: level mode follows enabled status.
  always_comb begin
    if (mode_r.trigger) begin
      irq_active = (edge_state_r == hig_pkg::EDGE_PULSE);
    end else begin
      irq_active = |(status_r & enable_r);
    end
    irq_active = irq_active && mode_r.global_en;
  end

  // The line runs on the always-on bus clock, so gated core clocks never silence it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_pin_r <= 1'b1;
    end else begin
      irq_pin_r <= mode_r.polarity ? irq_active : !irq_active;
    end
  end

  // Outputs straight from flip-flops.
  assign s_axil_awready = awready_r;
  assign s_axil_wready = wready_r;
  assign s_axil_bvalid = bvalid_r;
  assign s_axil_bresp = bresp_r;
  assign s_axil_arready = arready_r;
  assign s_axil_rvalid = rvalid_r;
  assign s_axil_rdata = rdata_r;
  assign s_axil_rresp = rresp_r;
  assign irq_pin = irq_pin_r;

endmodule : hig_irq_core
`default_nettype wire

// *** bench/hig_irq_core_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module hig_sva (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write side.
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic [1:0] s_axil_bresp,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // Read side.
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [hig_pkg::DATA_W-1:0] s_axil_rdata,
  input wire logic [1:0] s_axil_rresp,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves taken at one edge.
  sequence wr_take;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence
  // A response waiting on the master.
  sequence b_wait;
    s_axil_bvalid && !s_axil_bready;
  endsequence
  chk_aw_refused: assert property (s_axil_awvalid && s_axil_awready |=> !s_axil_awready)
    else $error("write address accepted twice in a row");
  chk_w_refused: assert property (s_axil_wvalid && s_axil_wready |=> !s_axil_wready)
    else $error("write data accepted twice in a row");
  chk_ar_refused: assert property (s_axil_arvalid && s_axil_arready |=> !s_axil_arready)
    else $error("read address accepted twice in a row");
  chk_wr_answer: assert property (wr_take |-> ##[1:2] s_axil_bvalid)
    else $error("write response late");
  chk_rd_answer: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read data late");
  chk_b_stands: assert property (b_wait |=> s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write response dropped early");
  chk_r_stands: assert property (s_axil_rvalid && !s_axil_rready |=> $stable(s_axil_rdata))
    else $error("read data changed while waiting");
  chk_b_drops: assert property (s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid)
    else $error("write response repeated");
  chk_decerr_zero: assert property (s_axil_rvalid && s_axil_rresp == hig_pkg::RESP_DECERR
    |-> s_axil_rdata == 32'h0) else $error("refused read returned data");
endmodule : hig_sva
bind hig_irq_core hig_sva hig_sva_i (.*);
`default_nettype wire

// *** bench/hig_cpu_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module hig_cpu_model (
  // Clock and the watched line.
  input wire logic aclk,
  input wire logic irq_pin,
  input wire logic act_high,
  // Measured pulse length and count.
  output var int width_last,
  output var int pulses
);
  int run;
  // Count active cycles at the level the processor is set for, and log each pulse.
  always_ff @(posedge aclk) begin
    if (irq_pin === act_high) begin
      run <= run + 1;
    end else begin
      if (run != 0) begin
        width_last <= run;
        pulses <= pulses + 1;
      end
      run <= 0;
    end
  end
endmodule : hig_cpu_model
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // Names match the design ports so that the instance connects by name.
  logic aclk, aresetn, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid;
  logic s_axil_rready, irq_pin, act_high;
  logic [7:0] s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata, rd_v;
  logic [3:0] s_axil_wstrb;
  logic [1:0] s_axil_bresp, s_axil_rresp, rd_r;
  logic [12:0] ext_event;
  logic [2:0][15:0] td_done;
  int errors, n_checks, cyc, width_last, pulses, p0, exp_w;
  hig_irq_core hig_irq_core_i (.*);
  hig_cpu_model hig_cpu_model_i (.aclk(aclk), .irq_pin(irq_pin), .act_high(act_high),
    .width_last(width_last), .pulses(pulses));
  // Free running clock.
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  // A hang counts as a mismatch.
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      stop_test();
    end
  end
  task stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Write: each channel released when taken, bready held until the response.
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 0;
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1;
    s_axil_wvalid <= 1;
    s_axil_bready <= 1;
    while (!done) begin
      @(posedge aclk);
      if (s_axil_awready) s_axil_awvalid <= 0;
      if (s_axil_wready) s_axil_wvalid <= 0;
      if (s_axil_bvalid) done = 1;
    end
    s_axil_bready <= 0;
    repeat (2) @(posedge aclk);
  endtask : wr
  task rd(input logic [7:0] a);
    logic done;
    done = 0;
    s_axil_araddr <= a;
    s_axil_arvalid <= 1;
    s_axil_rready <= 1;
    while (!done) begin
      @(posedge aclk);
      if (s_axil_arready) s_axil_arvalid <= 0;
      if (s_axil_rvalid) done = 1;
      rd_v = s_axil_rdata;
      rd_r = s_axil_rresp;
    end
    s_axil_rready <= 0;
    @(posedge aclk);
  endtask : rd
  // One-cycle controller event or descriptor completion, then let it settle.
  task pulse(input logic [12:0] e, input logic [47:0] t);
    ext_event <= e;
    td_done <= t;
    @(posedge aclk);
    ext_event <= '0;
    td_done <= '0;
    repeat (6) @(posedge aclk);
  endtask : pulse
  task t_reset();
    rd(hig_pkg::OFF_MODE);
    chk(rd_v, 32'h0);
    rd(hig_pkg::OFF_EDGE);
    chk(rd_v, 32'h21);
    chk(32'(irq_pin), 32'h1);
    rd(8'h7c);
    chk({rd_v[29:0], rd_r}, 32'(hig_pkg::RESP_DECERR));
  endtask : t_reset
  // Disabled event sets status only; zero writes keep, one writes clear.
  task t_status();
    wr(hig_pkg::OFF_MODE, 32'h1);
    pulse(13'h1, 48'h0);
    rd(hig_pkg::OFF_STATUS);
    chk(rd_v, 32'h8);
    chk(32'(irq_pin), 32'h1);
    wr(hig_pkg::OFF_STATUS, 32'h0);
    rd(hig_pkg::OFF_STATUS);
    chk(rd_v, 32'h8);
    wr(hig_pkg::OFF_STATUS, 32'h8);
    rd(hig_pkg::OFF_STATUS);
    chk(rd_v, 32'h0);
  endtask : t_status
  task t_level();
    wr(hig_pkg::OFF_ENABLE, 32'h8);
    pulse(13'h1, 48'h0);
    chk(32'(irq_pin), 32'h0);
    wr(hig_pkg::OFF_STATUS, 32'h0);
    chk(32'(irq_pin), 32'h0);
    wr(hig_pkg::OFF_STATUS, 32'h8);
    chk(32'(irq_pin), 32'h1);
    wr(hig_pkg::OFF_MODE, 32'h0);
    pulse(13'h1, 48'h0);
    chk(32'(irq_pin), 32'h1);
    wr(hig_pkg::OFF_MODE, 32'h5);
    chk(32'(irq_pin), 32'h1);
    wr(hig_pkg::OFF_STATUS, 32'h8);
    chk(32'(irq_pin), 32'h0);
  endtask : t_level
  // Edge pulses for two width codes; a clear during the pulse must not cut it.
  task t_edge();
    wr(hig_pkg::OFF_MODE, 32'h3);
    for (int code = 33; code <= 66; code += 33) begin
      wr(hig_pkg::OFF_EDGE, 32'(code));
      p0 = pulses;
      exp_w = (code * 65536 + 42948) / 42949 + 1;
      pulse(13'h1, 48'h0);
      wr(hig_pkg::OFF_STATUS, 32'h8);
      repeat (exp_w + 20) @(posedge aclk);
      chk(32'(pulses - p0), 32'h1);
      chk(32'(width_last >= exp_w - 2 && width_last <= exp_w + 2), 32'h1);
    end
  endtask : t_edge
  task t_masks();
    wr(hig_pkg::OFF_MODE, 32'h1);
    wr(hig_pkg::OFF_ENABLE, 32'h7);
    wr(hig_pkg::OFF_AND_BASE, 32'h16);
    wr(hig_pkg::OFF_OR_BASE + hig_pkg::OFF_STRIDE, 32'h80);
    pulse(13'h0, 48'h6);
    rd(hig_pkg::OFF_STATUS);
    chk(rd_v, 32'h0);
    pulse(13'h0, 48'h10);
    rd(hig_pkg::OFF_STATUS);
    chk(rd_v, 32'h1);
    chk(32'(irq_pin), 32'h0);
    pulse(13'h0, {16'h0, 16'h80, 16'h0});
    rd(hig_pkg::OFF_STATUS);
    chk(rd_v, 32'h3);
    rd(hig_pkg::OFF_DONE_BASE);
    chk(rd_v, 32'h16);
  endtask : t_masks
  // Reset for three cycles, then run each scenario in turn.
  initial begin
    aresetn = 0;
    act_high = 0;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = '0;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata, ext_event, td_done} = '0;
    s_axil_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    t_reset();
    t_status();
    t_level();
    t_edge();
    t_masks();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
